//--- pld_regs_map.svh
// register offsets, field positions, masks and reset values of the logic-array register bank
`ifndef PLD_REGS_MAP_SVH
`define PLD_REGS_MAP_SVH

// ******************************************************************
// register offsets
// ******************************************************************
`define OFS_INPUT_CELL_A          8'h0A
`define OFS_INPUT_CELL_B          8'h0B
`define OFS_INPUT_CELL_C          8'h1A
`define OFS_OUTPUT_CELL_BANK_A    8'h20
`define OFS_OUTPUT_CELL_BANK_B    8'h21
`define OFS_CELL_WRITE_MASK_A     8'h22
`define OFS_CELL_WRITE_MASK_B     8'h23
`define OFS_MAIN_SECTOR_LOCK      8'hC0
`define OFS_BOOT_SECTOR_LOCK      8'hC2
`define OFS_TEST_PORT_ENABLE      8'hC7
`define OFS_POWER_CTRL_FIRST      8'hB0
`define OFS_POWER_CTRL_SECOND     8'hB4
`define OFS_LOGIC_PAGE_SELECT     8'hE0

// ******************************************************************
// writable bit masks
// ******************************************************************
`define MASK_TEST_PORT_ENABLE     8'h01
`define MASK_POWER_CTRL_FIRST     8'h3A
`define MASK_POWER_CTRL_SECOND    8'h7D

// ******************************************************************
// field positions
// ******************************************************************
`define BIT_TEST_PORT_ON          0
`define BIT_AUTO_POWER_DOWN       1
`define BIT_TURBO_OFF             3
`define BIT_ARRAY_CLK_OFF         4
`define BIT_CELL_CLK_OFF          5
`define BIT_ADDR_BLOCK            0
`define BIT_BUS_CONTROL_INPUT_0_OFF             2
`define BIT_BUS_CONTROL_INPUT_1_OFF             3
`define BIT_BUS_CONTROL_INPUT_2_OFF             4
`define BIT_ALE_OFF               5
`define BIT_HIGH_WRITE_OFF        6
`define BIT_SECURITY_LOCK         7
`define BOOT_SECTOR_MSB           3

// ******************************************************************
// reset values
// ******************************************************************
`define RST_BYTE                  8'h00
`define RST_NIBBLE                4'h0
`define RST_CONTROL               3'h0

`endif

//--- pld_regs_pkg.sv
// shared types of the logic-array register bank
package pld_regs_pkg;

   typedef logic [7:0] byte_t;
   typedef logic [3:0] nibble_t;

endpackage

//--- pin_sync.sv
// two-stage synchroniser for pin-level inputs
module pin_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   // asynchronous pins in, synchronised levels out
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] firstStage;

   // first stage feeds only the second stage
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         firstStage <= '0;
         syncOut    <= '0;
      end else begin
         firstStage <= pinIn;
         syncOut    <= firstStage;
      end
   end

endmodule

//--- output_cell_bank.sv
// one bank of output logic cells with per-bit host write mask
module output_cell_bank #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   // host side
   input  wire logic             hostLoad,
   input  wire logic [WIDTH-1:0] hostData,
   input  wire logic [WIDTH-1:0] writeMask,
   // logic array side
   input  wire logic             cellTick,
   input  wire logic [WIDTH-1:0] arrayNext,
   output logic      [WIDTH-1:0] cellOut
);

   logic [WIDTH-1:0] loadBits;
   logic [WIDTH-1:0] next_cellOut;

   // a masked bit keeps its value against the host; the array may still clock it
   assign loadBits     = hostLoad ? ~writeMask : '0;
   assign next_cellOut = (loadBits & hostData)
                       | (~loadBits & (cellTick ? arrayNext : cellOut));

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cellOut <= '0;
      end else begin
         cellOut <= next_cellOut;
      end
   end

endmodule

//--- pld_cell_protect_power_regs.sv
// host register bank for logic cells, flash protection status, test port, page and power control
`include "pld_regs_map.svh"

module pld_cell_protect_power_regs (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   // host register port, synchronous to core_clk
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   output logic      [7:0] regRdData,
   output logic            regRdValid,
   // input cell pins of ports a, b and c
   input  wire logic [7:0] inCellPinsA,
   input  wire logic [7:0] inCellPinsB,
   input  wire logic [7:0] inCellPinsC,
   // protection status from non-volatile configuration
   input  wire logic [7:0] mainSectorLocks,
   input  wire logic [3:0] bootSectorLocks,
   input  wire logic       securityLockSet,
   // next values computed by the logic array for the output cells
   input  wire logic [7:0] arrayNextA,
   input  wire logic [7:0] arrayNextB,
   // raw inputs headed for the logic array
   input  wire logic       logicClockInput,
   input  wire logic [7:0] hostAddrLow,
   input  wire logic [3:0] portFLowNibble,
   input  wire logic [3:0] addrDataUpperNibble,
   input  wire logic       wideHostMode,
   input  wire logic [2:0] busControlInput,
   input  wire logic       addrLatchEnable,
   input  wire logic       highWriteByteEnable,
   // output cells
   output logic      [7:0] outputCellsA,
   output logic      [7:0] outputCellsB,
   // control to the rest of the device
   output logic            testPortOn,
   output logic      [7:0] logicPage,
   output logic            autoPowerDown,
   output logic            turboOff,
   output logic            arrayWake,
   // gated inputs into the logic array
   output logic            arrayClock,
   output logic            cellClockTick,
   output logic      [7:0] arrayAddrLow,
   output logic      [2:0] arrayBusControl,
   output logic            arrayAddrLatch,
   output logic            arrayHighWrite
);

   // ******************************************************************
   // decode helper
   // ******************************************************************
   function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] offset);
      addrHit = (addr == offset);
   endfunction

   // ******************************************************************
   // pin synchronisation
   // ******************************************************************
   localparam int PIN_WIDTH = 46;

   logic [PIN_WIDTH-1:0] pinsRaw;
   logic [PIN_WIDTH-1:0] pinsSync;

   assign pinsRaw = {inCellPinsA, inCellPinsB, inCellPinsC, logicClockInput, hostAddrLow,
                     portFLowNibble, addrDataUpperNibble, busControlInput, addrLatchEnable,
                     highWriteByteEnable};

   pin_sync #(
      .WIDTH   (PIN_WIDTH)
   ) u_pin_sync (
      .core_clk(core_clk),
      .rst_b   (rst_b),
      .pinIn   (pinsRaw),
      .syncOut (pinsSync)
   );

   pld_regs_pkg::byte_t   cellsA;
   pld_regs_pkg::byte_t   cellsB;
   pld_regs_pkg::byte_t   cellsC;
   logic                  clkLevel;
   pld_regs_pkg::byte_t   addrNarrow;
   pld_regs_pkg::nibble_t portFNib;
   pld_regs_pkg::nibble_t adioNib;
   logic [2:0]            controlSync;
   logic                  aleSync;
   logic                  highWriteSync;

   assign cellsA        = pinsSync[45:38];
   assign cellsB        = pinsSync[37:30];
   assign cellsC        = pinsSync[29:22];
   assign clkLevel      = pinsSync[21];
   assign addrNarrow    = pinsSync[20:13];
   assign portFNib      = pinsSync[12:9];
   assign adioNib       = pinsSync[8:5];
   assign controlSync   = pinsSync[4:2];
   assign aleSync       = pinsSync[1];
   assign highWriteSync = pinsSync[0];

   // ******************************************************************
   // write decode
   // ******************************************************************
   logic hitCellA;
   logic hitCellB;
   logic hitMaskA;
   logic hitMaskB;
   logic hitTest;
   logic hitPowerFirst;
   logic hitPowerSecond;
   logic hitPage;

   assign hitCellA       = regWrite && addrHit(regAddr, `OFS_OUTPUT_CELL_BANK_A);
   assign hitCellB       = regWrite && addrHit(regAddr, `OFS_OUTPUT_CELL_BANK_B);
   assign hitMaskA       = regWrite && addrHit(regAddr, `OFS_CELL_WRITE_MASK_A);
   assign hitMaskB       = regWrite && addrHit(regAddr, `OFS_CELL_WRITE_MASK_B);
   assign hitTest        = regWrite && addrHit(regAddr, `OFS_TEST_PORT_ENABLE);
   assign hitPowerFirst  = regWrite && addrHit(regAddr, `OFS_POWER_CTRL_FIRST);
   assign hitPowerSecond = regWrite && addrHit(regAddr, `OFS_POWER_CTRL_SECOND);
   assign hitPage        = regWrite && addrHit(regAddr, `OFS_LOGIC_PAGE_SELECT);

   // ******************************************************************
   // writable registers
   // ******************************************************************
   pld_regs_pkg::byte_t cellWriteMaskA;
   pld_regs_pkg::byte_t cellWriteMaskB;
   pld_regs_pkg::byte_t testPortEnable;
   pld_regs_pkg::byte_t logicPageSelect;
   pld_regs_pkg::byte_t powerCtrlFirst;
   pld_regs_pkg::byte_t powerCtrlSecond;

   // spare bits are stripped on the way in so they can never read back as one
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cellWriteMaskA  <= `RST_BYTE;
         cellWriteMaskB  <= `RST_BYTE;
         testPortEnable  <= `RST_BYTE;
         logicPageSelect <= `RST_BYTE;
         powerCtrlFirst  <= `RST_BYTE;
         powerCtrlSecond <= `RST_BYTE;
      end else begin
         if (hitMaskA) begin
            cellWriteMaskA <= regWrData;
         end
         if (hitMaskB) begin
            cellWriteMaskB <= regWrData;
         end
         if (hitTest) begin
            testPortEnable <= regWrData & `MASK_TEST_PORT_ENABLE;
         end
         if (hitPage) begin
            logicPageSelect <= regWrData;
         end
         if (hitPowerFirst) begin
            powerCtrlFirst <= regWrData & `MASK_POWER_CTRL_FIRST;
         end
         if (hitPowerSecond) begin
            powerCtrlSecond <= regWrData & `MASK_POWER_CTRL_SECOND;
         end
      end
   end

   // ******************************************************************
   // power control fields
   // ******************************************************************
   logic apdEnable;
   logic turboIsOff;
   logic arrayClkOff;
   logic cellClkOff;
   logic addrBlocked;
   logic [2:0] controlOff;
   logic aleOff;
   logic highWriteOff;

   assign apdEnable    = powerCtrlFirst[`BIT_AUTO_POWER_DOWN];
   assign turboIsOff   = powerCtrlFirst[`BIT_TURBO_OFF];
   assign arrayClkOff  = powerCtrlFirst[`BIT_ARRAY_CLK_OFF];
   assign cellClkOff   = powerCtrlFirst[`BIT_CELL_CLK_OFF];
   assign addrBlocked  = powerCtrlSecond[`BIT_ADDR_BLOCK];
   assign controlOff   = {powerCtrlSecond[`BIT_BUS_CONTROL_INPUT_2_OFF], powerCtrlSecond[`BIT_BUS_CONTROL_INPUT_1_OFF],
                          powerCtrlSecond[`BIT_BUS_CONTROL_INPUT_0_OFF]};
   assign aleOff       = powerCtrlSecond[`BIT_ALE_OFF];
   assign highWriteOff = powerCtrlSecond[`BIT_HIGH_WRITE_OFF];

   // ******************************************************************
   // logic clock edge detection
   // ******************************************************************
   // edges are seen on the synchronised level, so the array sees them three cycles late
   logic clkLevelPrev;
   logic clkEdge;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         clkLevelPrev <= 1'b0;
      end else begin
         clkLevelPrev <= clkLevel;
      end
   end

   assign clkEdge = clkLevel ^ clkLevelPrev;

   // ******************************************************************
   // output cell banks
   // ******************************************************************
   logic cellRiseTick;

   // cell flops advance on a rising logic clock edge only while the clock is routed
   assign cellRiseTick = clkLevel && !clkLevelPrev && !cellClkOff;

   output_cell_bank #(
      .WIDTH    (8)
   ) u_bank_a (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .hostLoad (hitCellA),
      .hostData (regWrData),
      .writeMask(cellWriteMaskA),
      .cellTick (cellRiseTick),
      .arrayNext(arrayNextA),
      .cellOut  (outputCellsA)
   );

   output_cell_bank #(
      .WIDTH    (8)
   ) u_bank_b (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .hostLoad (hitCellB),
      .hostData (regWrData),
      .writeMask(cellWriteMaskB),
      .cellTick (cellRiseTick),
      .arrayNext(arrayNextB),
      .cellOut  (outputCellsB)
   );

   // ******************************************************************
   // gating of inputs into the logic array
   // ******************************************************************
   pld_regs_pkg::byte_t next_arrayAddrLow;
   pld_regs_pkg::byte_t addrSource;
   logic [2:0]          next_arrayBusControl;
   logic                next_arrayClock;
   logic                next_arrayWake;

   // in the wide host mode the low nibble comes from port f and the upper from the bus
   assign addrSource           = wideHostMode ? {adioNib, portFNib} : addrNarrow;
   assign next_arrayAddrLow    = addrBlocked ? `RST_BYTE : addrSource;
   assign next_arrayBusControl = controlSync & ~controlOff;
   assign next_arrayClock      = clkLevel && !arrayClkOff;
   // with turbo off, each logic clock change wakes the array if the clock is connected
   assign next_arrayWake       = clkEdge && turboIsOff && !arrayClkOff;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         arrayAddrLow    <= `RST_BYTE;
         arrayBusControl <= `RST_CONTROL;
         arrayAddrLatch  <= 1'b0;
         arrayHighWrite  <= 1'b0;
         arrayClock      <= 1'b0;
         arrayWake       <= 1'b0;
         cellClockTick   <= 1'b0;
      end else begin
         arrayAddrLow    <= next_arrayAddrLow;
         arrayBusControl <= next_arrayBusControl;
         arrayAddrLatch  <= aleSync && !aleOff;
         arrayHighWrite  <= highWriteSync && !highWriteOff;
         arrayClock      <= next_arrayClock;
         arrayWake       <= next_arrayWake;
         cellClockTick   <= cellRiseTick;
      end
   end

   // ******************************************************************
   // control outputs
   // ******************************************************************
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         testPortOn    <= 1'b0;
         logicPage     <= `RST_BYTE;
         autoPowerDown <= 1'b0;
         turboOff      <= 1'b0;
      end else begin
         testPortOn    <= testPortEnable[`BIT_TEST_PORT_ON];
         logicPage     <= logicPageSelect;
         autoPowerDown <= apdEnable;
         turboOff      <= turboIsOff;
      end
   end

   // ******************************************************************
   // read path
   // ******************************************************************
   pld_regs_pkg::byte_t bootStatus;
   pld_regs_pkg::byte_t readMux;

   // bits six to four of the boot status are spare and read as zero
   assign bootStatus = {securityLockSet, 3'h0, bootSectorLocks};

   always_comb begin
      case (regAddr)
         `OFS_INPUT_CELL_A:       readMux = cellsA;
         `OFS_INPUT_CELL_B:       readMux = cellsB;
         `OFS_INPUT_CELL_C:       readMux = cellsC;
         `OFS_OUTPUT_CELL_BANK_A: readMux = outputCellsA;
         `OFS_OUTPUT_CELL_BANK_B: readMux = outputCellsB;
         `OFS_CELL_WRITE_MASK_A:  readMux = cellWriteMaskA;
         `OFS_CELL_WRITE_MASK_B:  readMux = cellWriteMaskB;
         `OFS_MAIN_SECTOR_LOCK:   readMux = mainSectorLocks;
         `OFS_BOOT_SECTOR_LOCK:   readMux = bootStatus;
         `OFS_TEST_PORT_ENABLE:   readMux = testPortEnable;
         `OFS_POWER_CTRL_FIRST:   readMux = powerCtrlFirst;
         `OFS_POWER_CTRL_SECOND:  readMux = powerCtrlSecond;
         `OFS_LOGIC_PAGE_SELECT:  readMux = logicPageSelect;
         default:                 readMux = `RST_BYTE;
      endcase
   end

   // read data is captured once and held until the next read
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         regRdData  <= `RST_BYTE;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRead;
         if (regRead) begin
            regRdData <= readMux;
         end
      end
   end

endmodule

//--- pld_regs_check_sva.sv
// concurrent checks on the ports of the logic-array register bank
module pld_regs_check (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       rst_b,
   // host register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic       regWrite,
   input wire logic       regRead,
   input wire logic [7:0] regRdData,
   input wire logic       regRdValid,
   // status inputs
   input wire logic [7:0] mainSectorLocks,
   input wire logic [3:0] bootSectorLocks,
   input wire logic       securityLockSet,
   // control and gated outputs
   input wire logic       testPortOn,
   input wire logic [7:0] logicPage,
   input wire logic       autoPowerDown,
   input wire logic       turboOff,
   input wire logic       arrayWake,
   input wire logic       arrayClock,
   input wire logic [7:0] arrayAddrLow,
   input wire logic [2:0] arrayBusControl
);
   timeunit 1ns;
   timeprecision 100ps;
   // ******************************************************************
   // properties
   // ******************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   AST_RD_VALID: assert property (1 |=> regRdValid == $past(regRead)) else $error("read valid mismatch");
   AST_UNMAPPED: assert property (regRead && regAddr == 8'h55 |=> regRdData == 8'h00) else $error("unmapped");
   AST_MAIN_LOCK: assert property (regRead && regAddr == 8'hC0 |=> regRdData == $past(mainSectorLocks))
      else $error("main lock read");
   AST_BOOT_LOCK: assert property (regRead && regAddr == 8'hC2 |=>
      regRdData == {$past(securityLockSet), 3'h0, $past(bootSectorLocks)}) else $error("boot lock read");
   AST_PAGE: assert property (regWrite && regAddr == 8'hE0 |-> ##2 logicPage == $past(regWrData, 2))
      else $error("page out");
   AST_TEST_PORT: assert property (regWrite && regAddr == 8'hC7 |-> ##2 testPortOn == $past(regWrData[0], 2))
      else $error("test port");
   AST_POWER_BITS: assert property (regWrite && regAddr == 8'hB0 |-> ##2
      {turboOff, autoPowerDown} == {$past(regWrData[3], 2), $past(regWrData[1], 2)}) else $error("power bits");
   AST_CLK_OFF: assert property (regWrite && regAddr == 8'hB0 && regWrData[4] |-> ##2 !arrayClock)
      else $error("array clock");
   AST_ADDR_BLOCK: assert property (regWrite && regAddr == 8'hB4 && regWrData[0] |-> ##2 arrayAddrLow == 8'h00)
      else $error("addr block");
   AST_CTRL_OFF: assert property (regWrite && regAddr == 8'hB4 && regWrData[4:2] == 3'h7 |-> ##2
      arrayBusControl == 3'h0) else $error("control gate");
   AST_WAKE_TURBO: assert property (arrayWake |-> turboOff) else $error("wake with turbo");
endmodule
bind pld_cell_protect_power_regs pld_regs_check pld_regs_check_inst (.*);

//--- host_model.sv
// host bus model driving the register port of the bank
module host_model (
   // clock
   input  wire logic       core_clk,
   // register port
   output logic      [7:0] regAddr,
   output logic      [7:0] regWrData,
   output logic            regWrite,
   output logic            regRead,
   input  wire logic [7:0] regRdData,
   input  wire logic       regRdValid
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrite = 1'h0;
      regRead = 1'h0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'h1;
      @(posedge core_clk);
      regWrite <= 1'h0;
      regAddr <= ~a; // released address and data never show the old value
      regWrData <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'h1;
      @(posedge core_clk);
      regRead <= 1'h0;
      regAddr <= ~a;
      @(posedge core_clk);
      d = regRdData;
      v = regRdValid;
   endtask
endmodule

//--- pld_cell_protect_power_regs_tb.sv
// self-checking testbench of the logic-array register bank
module pld_cell_protect_power_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic       core_clk = 1'h0;
   logic       rst_b = 1'h0;
   logic [7:0] regAddr, regWrData, regRdData, inCellPinsA, inCellPinsB, inCellPinsC, mainSectorLocks;
   logic [7:0] arrayNextA, arrayNextB, hostAddrLow, outputCellsA, outputCellsB, logicPage, arrayAddrLow;
   logic [3:0] bootSectorLocks, portFLowNibble, addrDataUpperNibble;
   logic [2:0] busControlInput, arrayBusControl;
   logic       regWrite, regRead, regRdValid, securityLockSet, logicClockInput, wideHostMode;
   logic       addrLatchEnable, highWriteByteEnable, testPortOn, autoPowerDown, turboOff;
   logic       arrayWake, arrayClock, cellClockTick, arrayAddrLatch, arrayHighWrite, seenValid;
   logic [7:0] seenData;
   int         n_mismatch = 0;
   int         n_checks = 0;
   int         nWake = 0;
   int         nTick = 0;
   pld_cell_protect_power_regs pld_cell_protect_power_regs_inst (.*);
   host_model host_model_inst (.*);
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk) if (arrayWake === 1'h1) nWake++;
   always @(posedge core_clk) if (cellClockTick === 1'h1) nTick++;
   // ******************************************************************
   // helpers
   // ******************************************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      host_model_inst.rd(a, seenData, seenValid);
      chk({7'h0, seenValid}, 8'h01);
      chk(seenData, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ******************************************************************
   // scenarios
   // ******************************************************************
   task automatic t_reset;
      chk(logicPage, 8'h00);
      chk({4'h0, autoPowerDown, turboOff, testPortOn, arrayWake}, 8'h00);
      rdchk(8'hB0, 8'h00);
      rdchk(8'hB4, 8'h00);
      rdchk(8'h22, 8'h00);
   endtask
   task automatic t_cells;
      host_model_inst.wr(8'h22, 8'h0F);
      host_model_inst.wr(8'h23, 8'hF0);
      host_model_inst.wr(8'h20, 8'hFF);
      host_model_inst.wr(8'h21, 8'hAA);
      rdchk(8'h20, 8'hF0);
      rdchk(8'h21, 8'h0A);
      rdchk(8'h23, 8'hF0);
      chk(outputCellsB, 8'h0A);
      host_model_inst.wr(8'h22, 8'h00);
      host_model_inst.wr(8'h20, 8'h5A);
      rdchk(8'h20, 8'h5A);
   endtask
   task automatic t_inputs_locks;
      @(posedge core_clk);
      inCellPinsA <= 8'h81;
      inCellPinsB <= 8'h42;
      inCellPinsC <= 8'h3C;
      mainSectorLocks <= 8'hA5;
      bootSectorLocks <= 4'h9;
      securityLockSet <= 1'h1;
      tick(3);
      rdchk(8'h0A, 8'h81);
      rdchk(8'h0B, 8'h42);
      rdchk(8'h1A, 8'h3C);
      rdchk(8'hC0, 8'hA5);
      rdchk(8'hC2, 8'h89);
      host_model_inst.wr(8'hC2, 8'hFF);
      securityLockSet <= 1'h0;
      rdchk(8'hC2, 8'h09);
   endtask
   task automatic t_test_page;
      host_model_inst.wr(8'hC7, 8'hFF);
      host_model_inst.wr(8'hE0, 8'h5A);
      tick(1);
      chk({7'h0, testPortOn}, 8'h01);
      chk(logicPage, 8'h5A);
      rdchk(8'hC7, 8'h01);
      host_model_inst.wr(8'hC7, 8'h00);
      host_model_inst.wr(8'h55, 8'hFF);
      tick(1);
      chk({7'h0, testPortOn}, 8'h00);
      rdchk(8'h55, 8'h00);
   endtask
   task automatic t_power_first;
      host_model_inst.wr(8'hB0, 8'h3A); // spare bits of the first power register stay zero
      rdchk(8'hB0, 8'h3A);
      chk({6'h0, autoPowerDown, turboOff}, 8'h03);
      host_model_inst.wr(8'hB0, 8'h08); // spare bits written as zero
      arrayNextA <= 8'h3C;
      nWake = 0;
      nTick = 0;
      tick(2);
      chk({6'h0, autoPowerDown, turboOff}, 8'h01);
      @(posedge core_clk);
      logicClockInput <= 1'h1;
      tick(4);
      chk(outputCellsA, 8'h3C);
      chk({6'h0, arrayClock, 1'h0}, 8'h02);
      chk(8'(nWake), 8'h01);
      chk(8'(nTick), 8'h01);
      host_model_inst.wr(8'hB0, 8'h38);
      arrayNextA <= 8'hC3;
      logicClockInput <= 1'h0;
      tick(4);
      @(posedge core_clk);
      logicClockInput <= 1'h1;
      tick(4);
      chk(outputCellsA, 8'h3C);
      chk({7'h0, arrayClock}, 8'h00);
      chk(8'(nWake), 8'h01);
      chk(8'(nTick), 8'h01);
   endtask
   task automatic t_power_second;
      @(posedge core_clk);
      hostAddrLow <= 8'hC3;
      portFLowNibble <= 4'h6;
      addrDataUpperNibble <= 4'h9;
      busControlInput <= 3'h5;
      addrLatchEnable <= 1'h1;
      highWriteByteEnable <= 1'h1;
      tick(4);
      chk(arrayAddrLow, 8'hC3);
      chk({3'h0, arrayBusControl, arrayAddrLatch, arrayHighWrite}, 8'h17);
      host_model_inst.wr(8'hB4, 8'h30);
      tick(1);
      chk({3'h0, arrayBusControl, arrayAddrLatch, arrayHighWrite}, 8'h05);
      host_model_inst.wr(8'hB4, 8'hFF);
      tick(1);
      chk(arrayAddrLow, 8'h00);
      chk({3'h0, arrayBusControl, arrayAddrLatch, arrayHighWrite}, 8'h00);
      rdchk(8'hB4, 8'h7D);
      host_model_inst.wr(8'hB4, 8'h00);
      wideHostMode <= 1'h1;
      tick(4);
      chk(arrayAddrLow, 8'h96);
   endtask
   initial begin
      {inCellPinsA, inCellPinsB, inCellPinsC, mainSectorLocks, arrayNextA, arrayNextB, hostAddrLow} = '0;
      {bootSectorLocks, portFLowNibble, addrDataUpperNibble, busControlInput} = '0;
      {securityLockSet, logicClockInput, wideHostMode, addrLatchEnable, highWriteByteEnable} = '0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'h1;
      tick(1);
      t_reset;
      t_cells;
      t_inputs_locks;
      t_test_page;
      t_power_first;
      t_power_second;
      final_report;
   end
   // the whole run needs well under a thousand cycles, so this only trips on a hang
   initial begin
      #100000;
      n_mismatch++;
      final_report;
   end
endmodule
